// [design/task_file_consts.svh]
// Function
// RULE1: Fixed I/O blocks decode A2-A0; control codes 110, 111.
// RULE2: Both enables low: data register as one 16-bit word.
// RULE3: Low-lane byte pair at offset 0: even byte, then odd.
// RULE4: High-lane byte at offset 0 reaches error or feature.
// RULE5: Contiguous I/O decodes A3-A0 as the offset.
// RULE6: Contiguous I/O ignores address lines above A3.
// RULE7: Memory mode, A10 low, decodes A3-A0 likewise.
// RULE8: Window 400h-7FFh: even to offset 8, odd to 9.
// RULE9: Repeated bytes at 8 or 0 alternate even, odd.
// RULE10: Repeated words at 8, 9, 0 move consecutive words.
// RULE11: Byte at 9 is the odd byte; no repeated 9 bytes.
// RULE12: Word at offset 8: even byte low, odd high.
// RULE13: Aliases are a sequential FIFO, never random access.
// RULE14: Native mode decodes task select, control select and DMA grant.
// RULE15: Odd registers answer at even address on upper lane; in the I/O modes the code answers this way only at offsets 0 and 8.
// RULE16: Native: data 16 bit unless 8-bit feature; others 8 bit. The code keeps DMA grant cycles 16 bit even with the 8-bit feature.
// RULE17: Data is 8 bits in the long-command extension; the code keeps DMA cycles and card modes 16 bit.
// RULE18: Error bits 7,6,4,2,0 are flags; 5,3,1 read zero.
// RULE19: Sector count zero means 256 sectors.
// RULE20: Sector count zero after success, remaining sectors after failure.
// RULE21: In logical mode sector and cylinders give bits 23-0.
// RULE22: Drive/head bits 7,5 read one; bit 6 logical, bit 4 drive, 3-0 head.
// RULE23: Status read clears pending interrupt; alternate read does not.
// RULE24: Drive address: inverted head, write flag, active-low drives.
// RULE25: Writes at drive address offset are ignored.
// RULE26: Offsets A, B and C change nothing and read undefined.
`ifndef TASK_FILE_CONSTS_SVH
`define TASK_FILE_CONSTS_SVH
`define OFS_DATA        4'h0
`define OFS_ERROR       4'h1
`define OFS_COUNT       4'h2
`define OFS_SECTOR      4'h3
`define OFS_CYL_LOW     4'h4
`define OFS_CYL_HIGH    4'h5
`define OFS_DRIVE_HEAD  4'h6
`define OFS_STATUS      4'h7
`define OFS_DUP_EVEN    4'h8
`define OFS_DUP_ODD     4'h9
`define OFS_DUP_ERROR   4'hD
`define OFS_ALT_STATUS  4'hE
`define OFS_DRIVE_ADDR  4'hF
`define PRI_BLOCK       6'h1F
`define SEC_BLOCK       6'h17
`define PRI_CTRL_BLOCK  6'h3F
`define SEC_CTRL_BLOCK  6'h37
`define CTRL_ALT_CODE   3'h6
`define CTRL_DRV_CODE   3'h7
`define DH_ONES_MASK    8'hA0
`define DH_LBA_BIT      6
`define DH_DRV_BIT      4
`define STATUS_ERR_BIT  0
`define ERROR_USED_MASK 8'hD5
`define DCTL_IEN_N_BIT  1
`define DCTL_SRST_BIT   2
`define RESET_COUNT     8'h01
`define RESET_DH        8'hA0
`define RESET_STATUS    8'h50
`define UNDEF_READ      8'hFF
`endif

// [design/task_file_pkg.sv]
package task_file_pkg;
  typedef enum logic [1:0] {
    MODE_MEMORY  = 2'b00,
    MODE_IO_ANY  = 2'b01,
    MODE_IO_PRI  = 2'b10,
    MODE_IO_SEC  = 2'b11
  } card_mode_t;
  typedef struct packed {
    logic [15:0] data;
    logic        last;
  } buf_word_t;
  typedef struct packed {
    logic        hit;
    logic [3:0]  ofs;
    logic        wide;
    logic        upper;
  } decode_t;
endpackage : task_file_pkg

// [design/task_file_address_decoder.sv]
`timescale 1ns/100ps
`include "task_file_consts.svh"
module task_file_address_decoder
  import task_file_pkg::*;
(
  input  wire logic        clk,                    // 40 MHz clock.
  input  wire logic        rst_n,                  // Asynchronous reset, active low.
  input  wire logic        native_mode,            // High selects native disk mode.
  input  wire card_mode_t  card_mode,              // Card decode scheme.
  input  wire logic [10:0] addr,                   // Host address A10-A0.
  input  wire logic        attr_select_n,          // Attribute select, low for I/O.
  input  wire logic        low_byte_card_enable_n, // Low lane enable.
  input  wire logic        high_byte_card_enable_n,// High lane enable.
  input  wire logic        io_read_strobe_n,       // I/O read strobe.
  input  wire logic        io_write_strobe_n,      // I/O write strobe.
  input  wire logic        mem_read_strobe_n,      // Memory output enable.
  input  wire logic        mem_write_strobe_n,     // Memory write enable.
  input  wire logic        task_block_select_n,    // Native task select.
  input  wire logic        control_block_select_n, // Native control select.
  input  wire logic        dma_grant_n,            // Native DMA acknowledge.
  input  wire logic [15:0] host_data_in,           // Host write data.
  output logic      [15:0] host_data_out,          // Read data.
  output logic      [1:0]  host_data_oe,           // Lane drive enables, bit 1 high lane.
  output logic             wide_io_indicator_n,    // Low when a card I/O mode cycle hits the data register; stays high in native mode.
  input  wire logic        fill_valid,             // Card buffer word offered.
  input  wire logic [15:0] fill_data,              // Card buffer word.
  output logic             fill_ready,             // Buffer accepts a word.
  output logic             drain_valid,            // Host-written word available.
  output logic      [15:0] drain_data,             // Host-written word.
  input  wire logic        drain_ready,            // Card takes the word.
  input  wire logic        eight_bit_data,         // Set-feature 8-bit PIO.
  input  wire logic        long_extension,         // Long command extended bytes.
  input  wire logic        write_in_progress_n,    // Low while writing media.
  input  wire logic        cmd_done,               // Command finished pulse.
  input  wire logic        cmd_ok,                 // Finished without error.
  input  wire logic [7:0]  sectors_left,           // Remaining sectors on failure.
  input  wire logic [7:0]  status_in,              // Card status byte.
  input  wire logic [7:0]  error_in,               // Card error flags.
  input  wire logic        intr_event,             // Card interrupt request pulse.
  output logic             intr_pending,           // Pending interrupt.
  output logic             command_strobe,         // Command written pulse.
  output logic      [7:0]  command_code,           // Last command written.
  output logic      [7:0]  feature_select,         // Feature register.
  output logic      [7:0]  sector_count,           // Sector count, zero means 256.
  output logic      [27:0] block_address,          // Start sector/cylinder or logical.
  output logic             logical_addressing_select, // Logical block mode.
  output logic             drive_number_select,    // Drive 0 or 1.
  output logic      [7:0]  device_control          // Device control register.
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [22:0] sync1, sync2;
  logic [15:0] din1, din2;

  // Every host bus pin passes two flip-flops before any logic looks at it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 23'h7FFFFF;
      sync2 <= 23'h7FFFFF;
      din1  <= 16'h0000;
      din2  <= 16'h0000;
    end else begin
      sync1 <= {addr, attr_select_n, low_byte_card_enable_n, high_byte_card_enable_n,
                io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n,
                mem_write_strobe_n, task_block_select_n, control_block_select_n,
                dma_grant_n, 2'b11};
      sync2 <= sync1;
      din1  <= host_data_in;
      din2  <= din1;
    end
  end

  logic [10:0] a;
  logic        reg_n, ce1_n, ce2_n, io_read_strobe_n_n, io_write_strobe_n_n, oe_n, we_n, cs0_n, cs1_n, dack_n;
  assign {a, reg_n, ce1_n, ce2_n, io_read_strobe_n_n, io_write_strobe_n_n, oe_n, we_n, cs0_n, cs1_n, dack_n} =
    sync2[22:2];

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Steers lanes for a card-mode offset.
  function automatic decode_t card_decode(input logic [3:0] ofs, input logic low_n,
                                          input logic high_n, input logic is_io);
    decode_t d;
    d.hit   = 1'b1;
    d.ofs   = ofs;
    d.wide  = !low_n && !high_n;
    d.upper = 1'b0;
    if (low_n && !high_n && !ofs[0]) begin
      d.upper = 1'b1;                            // RULE15
      d.ofs   = (ofs == `OFS_DATA) ? `OFS_ERROR : ofs | 4'h1; // RULE4
      if (is_io && ofs != `OFS_DATA && !(ofs == `OFS_DUP_EVEN)) d.hit = 1'b0;
    end
    if (low_n && high_n) d.hit = 1'b0;
    return d;
  endfunction : card_decode

  decode_t dec;
  logic    rd_req, wr_req, is_io_cycle;

  // Picks the register for the current cycle in the active decode scheme.
  always_comb begin
    dec         = '0;
    rd_req      = 1'b0;
    wr_req      = 1'b0;
    is_io_cycle = 1'b0;
    if (native_mode) begin
      rd_req = !io_read_strobe_n_n;
      wr_req = !io_write_strobe_n_n;
      if (cs1_n && !cs0_n) begin
        dec.hit = 1'b1;                          // RULE14
        dec.ofs = {1'b0, a[2:0]};
      end else if (cs1_n && cs0_n && !dack_n) begin
        dec.hit = 1'b1;                          // RULE14
        dec.ofs = `OFS_DATA;
      end else if (!cs1_n && cs0_n && a[2:0] == `CTRL_ALT_CODE) begin
        dec.hit = 1'b1;                          // RULE14
        dec.ofs = `OFS_ALT_STATUS;
      end
      dec.wide = dec.hit && dec.ofs == `OFS_DATA && !eight_bit_data && !long_extension
                 || (!dack_n && cs0_n);          // RULE16 RULE17
    end else if (!reg_n && card_mode != MODE_MEMORY) begin
      rd_req      = !io_read_strobe_n_n;
      wr_req      = !io_write_strobe_n_n;
      is_io_cycle = 1'b1;
      if (card_mode == MODE_IO_ANY) begin
        dec = card_decode(a[3:0], ce1_n, ce2_n, 1'b1);   // RULE5 RULE6
      end else if (!a[3] && a[9:4] == ((card_mode == MODE_IO_PRI) ? `PRI_BLOCK
                                                                  : `SEC_BLOCK)) begin
        dec = card_decode({1'b0, a[2:0]}, ce1_n, ce2_n, 1'b1); // RULE1
      end else if (!a[3] && a[2:1] == 2'b11 &&
                   a[9:4] == ((card_mode == MODE_IO_PRI) ? `PRI_CTRL_BLOCK
                                                         : `SEC_CTRL_BLOCK)) begin
        dec = card_decode({3'b111, a[0]}, ce1_n, ce2_n, 1'b1); // RULE1
      end
    end else if (reg_n && card_mode == MODE_MEMORY) begin
      rd_req = !oe_n;
      wr_req = !we_n;
      if (!a[10]) dec = card_decode(a[3:0], ce1_n, ce2_n, 1'b0);   // RULE7
      else dec = card_decode({3'b100, a[0]}, ce1_n, ce2_n, 1'b0);   // RULE8 RULE13
    end
  end

  // ==========================================================================
  // Access edge detection
  // ==========================================================================
  logic access_q;
  logic access_now;
  assign access_now = rd_req || wr_req;

  // An access is acted on once, at the leading edge of its strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) access_q <= 1'b0;
    else        access_q <= access_now;
  end

  logic start, do_rd, do_wr, is_data;
  assign start   = access_now && !access_q && dec.hit;
  assign do_rd   = start && rd_req;
  assign do_wr   = start && wr_req && !rd_req;
  assign is_data = dec.ofs == `OFS_DATA || dec.ofs == `OFS_DUP_EVEN ||
                   dec.ofs == `OFS_DUP_ODD;

  // ==========================================================================
  // Read buffer: two-entry skid between card and host
  // ==========================================================================
  buf_word_t  rbuf [2];
  logic [1:0] rcnt;
  logic       rptr;
  logic       byte_phase;   // Low selects the even byte of the head word.
  logic       pop_rd;
  logic       byte_access;

  assign byte_access = !dec.wide;
  assign pop_rd = do_rd && is_data && rcnt != 2'd0 &&
                  (dec.wide || dec.ofs == `OFS_DUP_ODD || byte_phase);  // RULE10 RULE11

  // Words from the card enter; host reads leave in order.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt <= 2'd0;
      rptr <= 1'b0;
      rbuf[0] <= '0;
      rbuf[1] <= '0;
    end else begin
      if (fill_valid && rcnt != 2'd2) begin
        rbuf[rptr ^ rcnt[0]] <= '{data: fill_data, last: 1'b0};
      end
      if (pop_rd) rptr <= ~rptr;
      rcnt <= rcnt + {1'b0, fill_valid && rcnt != 2'd2} - {1'b0, pop_rd};  // RULE13
    end
  end

  // Even/odd byte step shared by reads and writes of the data port.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_phase <= 1'b0;
    end else if (start && is_data) begin
      if (dec.wide) byte_phase <= 1'b0;                              // RULE10
      else if (dec.ofs == `OFS_DUP_ODD) byte_phase <= 1'b0;          // RULE11
      else byte_phase <= ~byte_phase;                                // RULE3 RULE9
    end
  end

  assign fill_ready = rcnt != 2'd2;

  // ==========================================================================
  // Write buffer: assembles bytes into words for the card
  // ==========================================================================
  logic [15:0] wbuf [2];
  logic [1:0]  wcnt;
  logic        wptr;
  logic [7:0]  even_hold;
  logic        push_wr;
  logic [15:0] push_word;

  assign push_wr = do_wr && is_data && wcnt != 2'd2 &&
                   (dec.wide || dec.ofs == `OFS_DUP_ODD || byte_phase);
  assign push_word = dec.wide ? din2 :
                     {(dec.upper ? din2[15:8] : din2[7:0]), even_hold};      // RULE12

  // Host words enter; the card drains and may stall.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcnt      <= 2'd0;
      wptr      <= 1'b0;
      even_hold <= 8'h00;
      wbuf[0]   <= 16'h0000;
      wbuf[1]   <= 16'h0000;
    end else begin
      if (do_wr && is_data && byte_access && !byte_phase && dec.ofs != `OFS_DUP_ODD)
        even_hold <= din2[7:0];                                         // RULE3
      if (push_wr) wbuf[wptr ^ wcnt[0]] <= push_word;                    // RULE2
      if (drain_valid && drain_ready) wptr <= ~wptr;
      wcnt <= wcnt + {1'b0, push_wr} - {1'b0, drain_valid && drain_ready};
    end
  end

  // Head of the write buffer is registered toward the card.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_valid <= 1'b0;
      drain_data  <= 16'h0000;
    end else begin
      drain_valid <= wcnt != 2'd0 && !(drain_valid && drain_ready && wcnt == 2'd1);
      drain_data  <= (drain_valid && drain_ready) ? wbuf[~wptr] : wbuf[wptr];
    end
  end

  // ==========================================================================
  // Task file registers
  // ==========================================================================
  logic [7:0] wbyte;
  assign wbyte = dec.upper ? din2[15:8] : din2[7:0];

  // Host writes load the task file; the card updates the count on completion.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_select <= 8'h00;
      sector_count   <= `RESET_COUNT;
      block_address  <= 28'h0000000;
      logical_addressing_select <= 1'b0;
      drive_number_select <= 1'b0;
      device_control <= 8'h00;
      command_code   <= 8'h00;
      command_strobe <= 1'b0;
    end else begin
      command_strobe <= 1'b0;
      if (cmd_done) sector_count <= cmd_ok ? 8'h00 : sectors_left;      // RULE20
      if (do_wr) begin
        case (dec.ofs)
          `OFS_ERROR, `OFS_DUP_ERROR: feature_select <= wbyte;
          `OFS_COUNT:      sector_count <= wbyte;                       // RULE19
          `OFS_SECTOR:     block_address[7:0]   <= wbyte;               // RULE21
          `OFS_CYL_LOW:    block_address[15:8]  <= wbyte;               // RULE21
          `OFS_CYL_HIGH:   block_address[23:16] <= wbyte;               // RULE21
          `OFS_DRIVE_HEAD: begin
            block_address[27:24]      <= wbyte[3:0];                    // RULE22
            logical_addressing_select <= wbyte[`DH_LBA_BIT];
            drive_number_select       <= wbyte[`DH_DRV_BIT];
          end
          `OFS_STATUS: begin
            command_code   <= wbyte;
            command_strobe <= 1'b1;
          end
          `OFS_ALT_STATUS: device_control <= wbyte;
          default: ;                                                    // RULE25 RULE26
        endcase
      end
    end
  end

  // Pending interrupt: a new request wins over a clearing status read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) intr_pending <= 1'b0;
    else if (intr_event) intr_pending <= 1'b1;
    else if (do_rd && dec.ofs == `OFS_STATUS) intr_pending <= 1'b0;     // RULE23
  end

  // ==========================================================================
  // Read data path
  // ==========================================================================
  logic [7:0]  rbyte;
  logic [15:0] head;
  assign head = rbuf[rptr].data;

  // Selects the byte a register read returns.
  always_comb begin
    case (dec.ofs)
      `OFS_DATA, `OFS_DUP_EVEN: rbyte = byte_phase ? head[15:8] : head[7:0];   // RULE9
      `OFS_DUP_ODD:    rbyte = head[15:8];                                     // RULE11
      `OFS_ERROR, `OFS_DUP_ERROR: rbyte = error_in & `ERROR_USED_MASK;         // RULE18
      `OFS_COUNT:      rbyte = sector_count;
      `OFS_SECTOR:     rbyte = block_address[7:0];
      `OFS_CYL_LOW:    rbyte = block_address[15:8];
      `OFS_CYL_HIGH:   rbyte = block_address[23:16];
      `OFS_DRIVE_HEAD: rbyte = `DH_ONES_MASK | {1'b0, logical_addressing_select, 1'b0,
                                drive_number_select, block_address[27:24]};    // RULE22
      `OFS_STATUS, `OFS_ALT_STATUS: rbyte = status_in;                         // RULE23
      `OFS_DRIVE_ADDR: rbyte = {1'b1, write_in_progress_n, ~block_address[27:24],
                                ~drive_number_select, drive_number_select};    // RULE24
      default:         rbyte = `UNDEF_READ;                                    // RULE26
    endcase
  end

  // Read data and lane enables are registered for the whole strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out       <= 16'h0000;
      host_data_oe        <= 2'b00;
      wide_io_indicator_n <= 1'b1;
    end else begin
      wide_io_indicator_n <= !(is_io_cycle && dec.hit && is_data);
      if (!(rd_req && dec.hit)) begin
        host_data_oe <= 2'b00;
      end else if (start) begin
        if (dec.wide && is_data) begin
          host_data_out <= head;                                        // RULE2 RULE12
          host_data_oe  <= 2'b11;
        end else if (dec.upper) begin
          host_data_out <= {rbyte, 8'h00};                              // RULE4 RULE15
          host_data_oe  <= 2'b10;
        end else begin
          host_data_out <= {8'h00, rbyte};
          host_data_oe  <= 2'b01;
        end
      end
    end
  end

endmodule : task_file_address_decoder

// [sim/task_file_address_decoder_assertions.sv]
`timescale 1ns/100ps
// ==========
// Checks on the decoder ports.
module task_file_address_decoder_assertions (
  input wire logic        clk,               // Clock.
  input wire logic        rst_n,             // Reset.
  input wire logic        io_read_strobe_n,  // Read.
  input wire logic        mem_read_strobe_n, // Read.
  input wire logic [1:0]  host_data_oe,      // Lanes.
  input wire logic        command_strobe,    // Pulse.
  input wire logic        cmd_done,          // Done.
  input wire logic        cmd_ok,            // Ok.
  input wire logic [7:0]  sectors_left,      // Left.
  input wire logic [7:0]  sector_count,      // Count.
  input wire logic        intr_event,        // Event.
  input wire logic        intr_pending,      // Pending.
  input wire logic        drain_valid,       // Valid.
  input wire logic        drain_ready,       // Ready.
  input wire logic [15:0] drain_data         // Data.
);
  // High while no read strobe is low.
  wire logic rd_idle = io_read_strobe_n && mem_read_strobe_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_release: assert property (rd_idle [*5] |-> host_data_oe == 2'h0)
    else $error("Lanes driven with no read.");
  a_oe_cause: assert property ($rose(|host_data_oe) |-> !$past(rd_idle, 2))
    else $error("Lanes driven before a read.");
  a_count_ok: assert property (cmd_done && cmd_ok |-> ##[1:3] sector_count == 8'h00)
    else $error("Count not cleared.");
  a_count_fail: assert property (cmd_done && !cmd_ok |-> ##[1:3] sector_count == sectors_left)
    else $error("Count not remaining sectors.");
  a_intr_set: assert property (intr_event |-> ##[1:2] intr_pending)
    else $error("Interrupt not pending.");
  a_intr_hold: assert property (intr_pending && rd_idle |=> intr_pending)
    else $error("Interrupt lost without a read.");
  a_cmd_pulse: assert property (command_strobe |=> !command_strobe)
    else $error("Command strobe too long.");
  a_drain_hold: assert property (drain_valid && !drain_ready |=> drain_valid && $stable(drain_data))
    else $error("Drain word changed while stalled.");
endmodule : task_file_address_decoder_assertions

// [sim/host_bus_model.sv]
`timescale 1ns/100ps
// ==========
// Host bus controller that drives the card pins.
module host_bus_model (
  input  wire logic        clk,                     // Clock.
  input  wire logic [15:0] host_data_out,           // Read data.
  output logic      [10:0] addr,                    // Address.
  output logic             attr_select_n,           // Space.
  output logic             low_byte_card_enable_n,  // Low lane.
  output logic             high_byte_card_enable_n, // High lane.
  output logic             io_read_strobe_n,        // Read.
  output logic             io_write_strobe_n,       // Write.
  output logic             mem_read_strobe_n,       // Read.
  output logic             mem_write_strobe_n,      // Write.
  output logic      [15:0] host_data_in             // Write data.
);
  // Idle bus from time zero.
  initial begin
    {addr, attr_select_n, host_data_in} = 28'h0000000;
    {high_byte_card_enable_n, low_byte_card_enable_n} = 2'h3;
    {io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n} = 4'hF;
  end
  // One access: strobe low six cycles, read data taken before release.
  task acc(input logic w, m, input logic [10:0] a, input logic [1:0] ce,
           input logic [15:0] wd, output logic [15:0] rd);
    @(negedge clk);
    {addr, attr_select_n, host_data_in} = {a, m, wd};
    {high_byte_card_enable_n, low_byte_card_enable_n} = ce;
    if (m) {mem_write_strobe_n, mem_read_strobe_n} = w ? 2'b01 : 2'b10;
    else {io_write_strobe_n, io_read_strobe_n} = w ? 2'b01 : 2'b10;
    repeat (6) @(negedge clk);
    rd = host_data_out;
    {io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n} = 4'hF;
    {high_byte_card_enable_n, low_byte_card_enable_n} = 2'h3;
    host_data_in = ~wd;  // Released lines do not keep the last value.
    repeat (4) @(negedge clk);
  endtask : acc
endmodule : host_bus_model

// [sim/test_task_file_address_decoder.sv]
`timescale 1ns/100ps
// ==========
// Self-checking bench for the task file decoder.
module test_task_file_address_decoder;
  import task_file_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, native_mode = 1'b0, task_block_select_n = 1'b1;
  logic control_block_select_n = 1'b1, dma_grant_n = 1'b1, eight_bit_data = 1'b0;
  logic long_extension = 1'b0, write_in_progress_n = 1'b1, cmd_done = 1'b0, cmd_ok = 1'b0;
  logic fill_valid = 1'b0, drain_ready = 1'b0, intr_event = 1'b0;
  logic [15:0] fill_data = 16'h0000, host_data_out, drain_data, r, wd[4];
  logic [7:0] sectors_left = 8'h00, status_in = 8'h00, error_in = 8'h00, b[8];
  card_mode_t card_mode = MODE_IO_PRI;
  wire logic [10:0] addr;
  wire logic [15:0] host_data_in;
  wire logic attr_select_n, low_byte_card_enable_n, high_byte_card_enable_n;
  wire logic io_read_strobe_n, io_write_strobe_n, mem_read_strobe_n, mem_write_strobe_n;
  logic [1:0] host_data_oe;
  logic wide_io_indicator_n, fill_ready, drain_valid, intr_pending, command_strobe;
  logic logical_addressing_select, drive_number_select;
  logic [7:0] command_code, feature_select, sector_count, device_control;
  logic [27:0] block_address;
  int num_errors = 0, checked = 0, n;
  task_file_address_decoder uut (.*);
  host_bus_model host (.*);
  always #12.5 clk = ~clk;
  // Counts a comparison and reports a mismatch.
  task chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // Waits at falling edges for a flag, with a bound.
  task automatic wt(ref logic s);
    for (int k = 0; s !== 1'b1; k++) begin
      if (k > 60) begin
        num_errors++;
        end_of_test();
      end
      @(negedge clk);
    end
  endtask : wt
  // Host access through the bus model.
  task bus(input logic w, m, input logic [10:0] a, input logic [1:0] ce, input logic [15:0] v);
    host.acc(w, m, a, ce, v, r);
  endtask : bus
  // Offers one card word to the read buffer.
  task push(input logic [15:0] v);
    {fill_data, fill_valid} = {v, 1'b1};
    wt(fill_ready);
    @(negedge clk);
    {fill_data, fill_valid} = {~v, 1'b0};
  endtask : push
  // Takes one host word after a stall.
  task pull(input logic [15:0] e);
    wt(drain_valid);
    repeat (3) @(negedge clk);
    chk(drain_data, e);
    drain_ready = 1'b1;
    @(negedge clk);
    drain_ready = 1'b0;
  endtask : pull
  // Main sequence.
  initial begin
    n = $urandom(32'h95dc);
    {write_in_progress_n, status_in, error_in} = 17'($urandom);
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 2; i < 8; i++) begin
      b[i] = 8'($urandom);
      bus(1, 0, 11'h1F0 + 11'(i), 2'b10, {8'h00, b[i]});
    end
    for (int i = 2; i < 6; i++) begin
      bus(0, 0, 11'h1F0 + 11'(i), 2'b10, 16'h0000);
      chk(r[7:0], b[i]);
    end
    chk(command_code, b[7]);
    chk(block_address, {b[6][3:0], b[5], b[4], b[3]});
    chk({logical_addressing_select, drive_number_select}, {b[6][6], b[6][4]});
    bus(1, 0, 11'h3F7, 2'b10, 16'h00FF);
    bus(1, 0, 11'h3F6, 2'b10, {8'h00, b[2]});
    chk(device_control, b[2]);
    bus(0, 0, 11'h1F6, 2'b10, 16'h0000);
    chk(r[7:0], b[6] | 8'hA0);
    bus(0, 0, 11'h3F7, 2'b10, 16'h0000);
    chk(r[7:0], {1'b1, write_in_progress_n, ~b[6][3:0], ~b[6][4], b[6][4]});
    intr_event = 1'b1;
    @(negedge clk);
    intr_event = 1'b0;
    bus(0, 0, 11'h3F6, 2'b10, 16'h0000);
    chk(intr_pending, 1'b1);
    bus(0, 0, 11'h1F7, 2'b10, 16'h0000);
    chk({intr_pending, r[7:0]}, {1'b0, status_in});
    card_mode = MODE_IO_ANY;
    bus(1, 0, {7'($urandom), 4'h2}, 2'b10, {8'h00, b[7]});
    bus(0, 0, {7'($urandom), 4'h2}, 2'b10, 16'h0000);
    chk(r[7:0], b[7]);
    bus(0, 0, {7'($urandom), 4'hD}, 2'b10, 16'h0000);
    chk(r[7:0], error_in & 8'hD5);
    bus(0, 0, {7'($urandom), 4'h0}, 2'b01, 16'h0000);
    chk(r[15:8], error_in & 8'hD5);
    bus(1, 0, {7'($urandom), 4'h0}, 2'b01, {b[5], 8'h00});
    chk(feature_select, b[5]);
    card_mode = MODE_MEMORY;
    for (int i = 0; i < 4; i++) wd[i] = 16'($urandom);
    push(wd[0]);
    push(wd[1]);
    chk(fill_ready, 1'b0);
    bus(0, 1, 11'h000, 2'b00, 16'h0000);
    chk(r, wd[0]);
    bus(0, 1, 11'h008, 2'b10, 16'h0000);
    chk(r[7:0], wd[1][7:0]);
    bus(0, 1, 11'h008, 2'b10, 16'h0000);
    chk(r[7:0], wd[1][15:8]);
    push(wd[2]);
    push(wd[3]);
    bus(0, 1, 11'h008, 2'b10, 16'h0000);
    chk(r[7:0], wd[2][7:0]);
    bus(0, 1, 11'h009, 2'b10, 16'h0000);
    chk(r[7:0], wd[2][15:8]);
    bus(0, 1, {1'b1, 9'($urandom), 1'b0}, 2'b00, 16'h0000);
    chk(r, wd[3]);
    bus(1, 1, 11'h008, 2'b00, wd[0]);
    bus(1, 1, 11'h008, 2'b10, {8'h00, wd[1][7:0]});
    bus(1, 1, 11'h009, 2'b10, {8'h00, wd[1][15:8]});
    pull(wd[0]);
    pull(wd[1]);
    chk(drain_valid, 1'b0);
    {native_mode, task_block_select_n, sectors_left} = {2'b10, 8'($urandom)};
    bus(1, 0, 11'h002, 2'b10, {8'h00, b[4]});
    chk(sector_count, b[4]);
    for (int i = 0; i < 2; i++) begin
      {cmd_ok, cmd_done} = {i[0], 1'b1};
      @(negedge clk);
      cmd_done = 1'b0;
      repeat (3) @(negedge clk);
      chk(sector_count, i[0] ? 8'h00 : sectors_left);
    end
    {task_block_select_n, control_block_select_n} = 2'b10;
    bus(0, 0, 11'h006, 2'b10, 16'h0000);
    chk(r[7:0], status_in);
    end_of_test();
  end
endmodule : test_task_file_address_decoder
bind task_file_address_decoder task_file_address_decoder_assertions chk_i (.*);
